// >>> dsol_map.vh
// constants for the drive status output block: register offsets, fields, codes, timing
// assumes a 32-bit classic wishbone slave with byte addresses, one word per register
`ifndef DSOL_MAP_VH
`define DSOL_MAP_VH

`define DSOL_REG_CTRL 8'h00
`define DSOL_REG_SLOT0 8'h04
`define DSOL_REG_SLOT4 8'h14
`define DSOL_REG_PERM 8'h18
`define DSOL_REG_PCT 8'h1c
`define DSOL_REG_DLY 8'h20
`define DSOL_REG_STAT 8'h24
`define DSOL_REG_IRQ_ST 8'h28
`define DSOL_REG_IRQ_MSK 8'h2c

`define DSOL_FN_OFF 4'h0
`define DSOL_FN_ALARM 4'h7
`define DSOL_FN_PREALARM 4'ha
`define DSOL_FN_WARN 4'hb
`define DSOL_FN_POSITION_COMMAND_DONE_OUT 4'hc

`define DSOL_LINK_232 2'h0
`define DSOL_LINK_422 2'h1
`define DSOL_LINK_485 2'h2

`define DSOL_DISP_NONE 8'h00
`define DSOL_DISP_FAULT 8'h06
`define DSOL_DISP_PREALERT 8'h17

`define DSOL_PERM_RST 16'h1f40
`define DSOL_PCT_RST 7'h64
`define DSOL_DLY_RST 16'h0000

// time base: 1 ms ticks at 20 MHz
`define DSOL_TICK_NS 1000000
`define DSOL_CLK_NS 50

`define DSOL_IRQ_PRE 0
`define DSOL_IRQ_FAULT 1
`define DSOL_IRQ_WARN 2
`define DSOL_IRQ_DONE 3

`endif

// >>> dsol_status_out.v
// drive status output logic: overload pre-alarm and fault, warning, command done, slot mux
// assumes monitor inputs synchronous to clk_i and a classic wishbone master
`timescale 1ns/1ns
`include "dsol_map.vh"

module dsol_status_out #(
  parameter SLOTS = 5,
  parameter TICK_CYCLES = `DSOL_TICK_NS / `DSOL_CLK_NS
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  // drive monitors
  input wire overload_i,
  input wire rev_limit_err_i,
  input wire fwd_limit_err_i,
  input wire estop_i,
  input wire serial_err_i,
  input wire undervolt_i,
  input wire other_fault_i,
  input wire pos_cmd_end_i,
  // status outputs
  output reg [SLOTS-1:0] slot_out_o,
  output reg overload_prealarm_out_o,
  output reg servo_fault_out_o,
  output reg [7:0] display_code_o,
  output reg [2:0] link_enable_o,
  output wire irq_o
);

  // counter width follows the tick period, so another clock rate needs no edit
  function integer cnt_width;
    input integer n;
    integer v;
    begin
      cnt_width = 1;
      for (v = 2; v < n; v = v * 2) begin
        cnt_width = cnt_width + 1;
      end
    end
  endfunction

  localparam TICK_W = cnt_width(TICK_CYCLES);
  localparam DONE_IDLE = 2'h0;
  localparam DONE_WAIT = 2'h1;
  localparam DONE_SET = 2'h2;

  reg [3:0] slot_fn [0:SLOTS-1];
  reg [15:0] perm_time;
  reg [6:0] overload_percentage_setting;
  reg [15:0] command_done_delay_setting;
  reg [1:0] link_mode_select;
  reg [3:0] irq_st;
  reg [3:0] irq_msk;

  reg [TICK_W-1:0] tick_cnt;
  reg [15:0] ovl_ms;
  reg [15:0] dly_ms;
  reg pre_hit;
  reg fault_hit;
  reg overload_fault_code;
  reg warn_out;
  reg warn_seen;
  reg done_out;
  reg [1:0] done_state;
  reg [3:0] prev_ev;
  reg [31:0] next_dat_o;

  wire tick;
  wire [22:0] ovl_scaled;
  wire [22:0] thr_scaled;
  wire warn_cond;
  wire [3:0] ev;
  wire [3:0] ev_rise;
  wire wb_req;
  wire [3:0] wr_clr;
  wire wb_wr;
  wire wb_rd;
  wire [SLOTS-1:0] next_slot;
  integer k;

  function integer slot_index;
    input [7:0] adr;
    begin
      slot_index = (adr - `DSOL_REG_SLOT0) >> 2;
    end
  endfunction

  function slot_hit;
    input [7:0] adr;
    begin
      slot_hit = (adr >= `DSOL_REG_SLOT0) && (adr <= `DSOL_REG_SLOT4) &&
                 (adr[1:0] == 2'b00) && (slot_index(adr) < SLOTS);
    end
  endfunction

  // one slot's level for its function code; unknown codes stay off
  function slot_source;
    input [3:0] fn;
    input alarm;
    input prealarm;
    input warn;
    input done;
    begin
      case (fn)
        `DSOL_FN_OFF: slot_source = 1'b0;
        `DSOL_FN_ALARM: slot_source = alarm;
        `DSOL_FN_PREALARM: slot_source = prealarm;
        `DSOL_FN_WARN: slot_source = warn;
        `DSOL_FN_POSITION_COMMAND_DONE_OUT: slot_source = done;
        default: slot_source = 1'b0;
      endcase
    end
  endfunction

  function [2:0] link_onehot;
    input [1:0] mode;
    begin
      case (mode)
        `DSOL_LINK_422: link_onehot = 3'b010;
        `DSOL_LINK_485: link_onehot = 3'b100;
        default: link_onehot = 3'b001;
      endcase
    end
  endfunction

  assign tick = (tick_cnt == TICK_CYCLES - 1);
  // compare ovl*100 against perm*pct to avoid a divider
  assign ovl_scaled = ovl_ms * 7'd100;
  assign thr_scaled = perm_time * overload_percentage_setting;
  assign warn_cond = rev_limit_err_i | fwd_limit_err_i | estop_i | serial_err_i |
                     undervolt_i;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_rd = wb_req & ~wb_we_i;
  assign wb_err_o = 1'b0;
  assign ev = {done_out, warn_out, servo_fault_out_o, overload_prealarm_out_o};
  assign ev_rise = ev & ~prev_ev;
  assign wr_clr = (wb_req && wb_we_i && wb_adr_i == `DSOL_REG_IRQ_ST && wb_sel_i[0]) ?
                  wb_dat_i[3:0] : 4'h0;
  assign irq_o = |(irq_st & irq_msk);

  // millisecond tick
  always @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt <= {TICK_W{1'b0}};
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // overload accumulation
  always @(posedge clk_i) begin
    if (rst_i || !overload_i) begin
      ovl_ms <= 16'h0000;
      pre_hit <= 1'b0;
      fault_hit <= 1'b0;
    end else begin
      if (tick && ovl_ms != 16'hffff) begin
        ovl_ms <= ovl_ms + 16'h0001;
      end
      pre_hit <= (ovl_scaled > thr_scaled);
      fault_hit <= (ovl_ms > perm_time);
    end
  end

  // fault latches until reset; pre-alarm follows the overload interval
  always @(posedge clk_i) begin
    if (rst_i) begin
      overload_fault_code <= 1'b0;
      overload_prealarm_out_o <= 1'b0;
      servo_fault_out_o <= 1'b0;
      warn_out <= 1'b0;
      warn_seen <= 1'b0;
      display_code_o <= `DSOL_DISP_NONE;
    end else begin
      overload_prealarm_out_o <= pre_hit;
      if (fault_hit) begin
        overload_fault_code <= 1'b1;
      end
      warn_out <= warn_cond;
      warn_seen <= warn_cond;
      // alarm only after warning has been shown for a cycle
      servo_fault_out_o <= overload_fault_code | fault_hit | other_fault_i |
                           (warn_cond & warn_seen);
      if (overload_fault_code || fault_hit) begin
        display_code_o <= `DSOL_DISP_FAULT;
      end else if (pre_hit) begin
        display_code_o <= `DSOL_DISP_PREALERT;
      end else begin
        display_code_o <= `DSOL_DISP_NONE;
      end
    end
  end

  // command done: wait for the end of the position command, then count the delay
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_state <= DONE_IDLE;
      dly_ms <= 16'h0000;
      done_out <= 1'b0;
    end else begin
      case (done_state)
        DONE_IDLE: begin
          dly_ms <= 16'h0000;
          done_out <= 1'b0;
          if (pos_cmd_end_i) begin
            done_state <= DONE_WAIT;
          end
        end
        DONE_WAIT: begin
          if (!pos_cmd_end_i) begin
            done_state <= DONE_IDLE;
          end else if (dly_ms >= command_done_delay_setting) begin
            done_out <= 1'b1;
            done_state <= DONE_SET;
          end else if (tick) begin
            dly_ms <= dly_ms + 16'h0001;
          end
        end
        DONE_SET: begin
          if (!pos_cmd_end_i) begin
            done_out <= 1'b0;
            done_state <= DONE_IDLE;
          end
        end
        default: begin
          done_out <= 1'b0;
          done_state <= DONE_IDLE;
        end
      endcase
    end
  end

  // slot multiplexer; one register stage for all slots
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : g_slot
      assign next_slot[g] = slot_source(slot_fn[g], servo_fault_out_o,
                                        overload_prealarm_out_o, warn_out, done_out);
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      slot_out_o <= {SLOTS{1'b0}};
    end else begin
      slot_out_o <= next_slot;
    end
  end

  // link mode one-hot
  always @(posedge clk_i) begin
    if (rst_i) begin
      link_enable_o <= 3'b001;
    end else begin
      link_enable_o <= link_onehot(link_mode_select);
    end
  end

  // interrupt status: set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= 4'h0;
      prev_ev <= 4'h0;
    end else begin
      prev_ev <= ev;
      irq_st <= (irq_st & ~wr_clr) | ev_rise;
    end
  end

  // wishbone register file, one-cycle ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      perm_time <= `DSOL_PERM_RST;
      overload_percentage_setting <= `DSOL_PCT_RST;
      command_done_delay_setting <= `DSOL_DLY_RST;
      link_mode_select <= `DSOL_LINK_232;
      irq_msk <= 4'h0;
      for (k = 0; k < SLOTS; k = k + 1) begin
        slot_fn[k] <= `DSOL_FN_OFF;
      end
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= next_dat_o;
      if (wb_wr) begin
        if (slot_hit(wb_adr_i) && wb_sel_i[0]) begin
          slot_fn[slot_index(wb_adr_i)] <= wb_dat_i[3:0];
        end
        case (wb_adr_i)
          `DSOL_REG_CTRL: begin
            // out-of-range mode stays on the previous link
            if (wb_sel_i[0] && wb_dat_i[1:0] != 2'h3) begin
              link_mode_select <= wb_dat_i[1:0];
            end
          end
          `DSOL_REG_PERM: begin
            if (wb_sel_i[0]) perm_time[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) perm_time[15:8] <= wb_dat_i[15:8];
          end
          `DSOL_REG_PCT: begin
            if (wb_sel_i[0]) overload_percentage_setting <= wb_dat_i[6:0];
          end
          `DSOL_REG_DLY: begin
            if (wb_sel_i[0]) command_done_delay_setting[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) command_done_delay_setting[15:8] <= wb_dat_i[15:8];
          end
          `DSOL_REG_IRQ_MSK: begin
            if (wb_sel_i[0]) irq_msk <= wb_dat_i[3:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; zero outside a read keeps the data lines quiet between acks
  always @* begin
    next_dat_o = 32'h00000000;
    if (wb_rd) begin
      if (slot_hit(wb_adr_i)) begin
        next_dat_o = {28'h0000000, slot_fn[slot_index(wb_adr_i)]};
      end
      case (wb_adr_i)
        `DSOL_REG_CTRL: next_dat_o = {29'h0, link_enable_o[2:1] != 2'b00,
                                      link_mode_select};
        `DSOL_REG_PERM: next_dat_o = {16'h0000, perm_time};
        `DSOL_REG_PCT: next_dat_o = {25'h0, overload_percentage_setting};
        `DSOL_REG_DLY: next_dat_o = {16'h0000, command_done_delay_setting};
        `DSOL_REG_STAT: next_dat_o = {16'h0000, display_code_o, 3'h0,
                                      overload_fault_code, ev};
        `DSOL_REG_IRQ_ST: next_dat_o = {28'h0000000, irq_st};
        `DSOL_REG_IRQ_MSK: next_dat_o = {28'h0000000, irq_msk};
        default: begin
        end
      endcase
    end
  end

endmodule

// >>> dsol_status_out_properties.sv
// checker for the status output block: bus timing, link select, overload and alarm outputs
// assumes one clock and a sync active-high reset; bound to the top module
`timescale 1ns/1ns
module dsol_status_out_props (
  // clock, reset, bus
  input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o,
  input wire [31:0] wb_dat_o,
  // monitors and outputs
  input wire overload_i, estop_i, overload_prealarm_out_o, servo_fault_out_o,
  input wire [2:0] link_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data leak");
  chk_err_low: assert property (!wb_err_o) else $error("err raised");
  chk_link_onehot: assert property ($onehot(link_enable_o)) else $error("link");
  chk_pre_cause: assert property (overload_prealarm_out_o |-> $past(overload_i, 3))
    else $error("prealarm without overload");
  chk_pre_drop: assert property ($fell(overload_i) |-> ##3 !overload_prealarm_out_o)
    else $error("prealarm stuck");
  chk_estop_alarm: assert property (estop_i && $past(estop_i) |-> ##[1:2] servo_fault_out_o)
    else $error("no alarm");
  cov_pre: cover property ($rose(overload_prealarm_out_o));
  cov_fault: cover property ($rose(servo_fault_out_o));
  cov_read: cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule
bind dsol_status_out dsol_status_out_props u_props (.*);

// >>> dsol_ctrl_model.sv
// external controller model: remembers which status outputs were ever seen high
// assumes outputs synchronous to clk_i
`timescale 1ns/1ns
module dsol_ctrl_model (
  input wire clk_i,
  input wire [4:0] slot_i,
  output reg [4:0] seen_o
);
  initial seen_o = 5'h0;
  always @(posedge clk_i) seen_o <= seen_o | slot_i;
endmodule

// >>> testbench.sv
// self-checking bench for the status output block
// assumes TICK_CYCLES=4, so one ms is four clocks
`timescale 1ns/1ns
`include "dsol_map.vh"
module testbench;
  reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ov = 0, oth = 0, pos = 0;
  reg [7:0] adr = 8'h0;
  reg [31:0] dat = 32'h0, r = 32'hff797fad;
  reg [4:0] flt = 5'h0;
  wire [31:0] wb_dat_o;
  wire [4:0] slot_out_o, seen;
  wire [7:0] disp;
  wire [2:0] link;
  wire wb_ack_o, pre, fault, irq_o;
  integer mismatches = 0, checked = 0, i, k, tw, ta;
  logic [31:0] exp_q[$];
  always #25 clk_i = ~clk_i;
  dsol_status_out #(.TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(), .overload_i(ov),
    .rev_limit_err_i(flt[0]), .fwd_limit_err_i(flt[1]), .estop_i(flt[2]),
    .serial_err_i(flt[3]), .undervolt_i(flt[4]), .other_fault_i(oth), .pos_cmd_end_i(pos),
    .slot_out_o(slot_out_o), .overload_prealarm_out_o(pre), .servo_fault_out_o(fault),
    .display_code_o(disp), .link_enable_o(link), .irq_o(irq_o));
  dsol_ctrl_model u_ctrl (.clk_i(clk_i), .slot_i(slot_out_o), .seen_o(seen));
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task test_done;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reads queue their expectation; the monitor below compares on ack
  task wb(input [7:0] a, input w, input [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    cyc <= 0; stb <= 0;
  endtask
  always @(posedge clk_i) if (wb_ack_o && !we) chk(wb_dat_o, exp_q.pop_front());
  task wt(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(`DSOL_REG_PERM, 0, 32'h1f40);
    wb(`DSOL_REG_PCT, 0, 32'h64);
    wb(`DSOL_REG_SLOT0, 0, 32'h0);
    wb(8'h30, 1, 32'hff);
    wb(8'h30, 0, 32'h0);
    for (i = 0; i < 4; i++) begin
      wb(`DSOL_REG_CTRL, 1, i);
      wt(2);
      chk(link, i == 3 ? 3'h4 : 3'h1 << i);
    end
    r = lfsr(r);
    wb(`DSOL_REG_DLY, 1, r);
    wb(`DSOL_REG_DLY, 0, {16'h0, r[15:0]});
    for (i = 0; i < 5; i++) wb(`DSOL_REG_SLOT0 + 4 * i, 1, i == 3 ? 7 : i == 4 ? 0 : 10 + i);
    for (i = 0; i < 5; i++) begin
      @(posedge clk_i) flt <= 5'h1 << i;
      tw = 0; ta = 0;
      for (k = 1; k < 10; k++) begin
        wt(1);
        if (slot_out_o[1] && tw == 0) tw = k;
        if (slot_out_o[3] && ta == 0) ta = k;
      end
      chk(tw != 0 && tw < ta, 1);
      @(posedge clk_i) flt <= 5'h0;
      wt(5);
      chk(slot_out_o, 5'h0);
    end
    @(posedge clk_i) oth <= 1;
    wt(5);
    chk(slot_out_o, 5'h08);
    @(posedge clk_i) oth <= 0;
    wb(`DSOL_REG_IRQ_ST, 0, 32'h6);
    wb(`DSOL_REG_IRQ_MSK, 1, 32'h4);
    wt(1);
    chk(irq_o, 1);
    wb(`DSOL_REG_IRQ_ST, 1, 32'hf);
    wt(1);
    chk(irq_o, 0);
    wb(`DSOL_REG_DLY, 1, 32'h3);
    @(posedge clk_i) pos <= 1;
    wt(6);
    chk(slot_out_o[2], 0);
    wt(14);
    chk(slot_out_o[2], 1);
    @(posedge clk_i) pos <= 0;
    wt(4);
    chk(slot_out_o[2], 0);
    wb(`DSOL_REG_PERM, 1, 32'd10);
    wb(`DSOL_REG_PCT, 1, 32'd60);
    @(posedge clk_i) ov <= 1;
    wt(24);
    chk({pre, slot_out_o[0]}, 0);
    wt(12);
    chk({fault, pre, slot_out_o[0], disp}, {3'h3, `DSOL_DISP_PREALERT});
    wt(16);
    chk({fault, slot_out_o[3], disp}, {2'h3, `DSOL_DISP_FAULT});
    @(posedge clk_i) ov <= 0;
    wt(4);
    chk({fault, pre, slot_out_o[0]}, 3'h4);
    repeat (2) begin
      @(posedge clk_i) ov <= 1;
      wt(20);
      chk(pre, 0);
      @(posedge clk_i) ov <= 0;
      wt(1);
    end
    wb(`DSOL_REG_STAT, 0, 32'h0612);
    chk(seen, 5'h0f);
    @(posedge clk_i) rst_i <= 1;
    wt(2);
    @(posedge clk_i) rst_i <= 0;
    wt(1);
    chk({fault, link}, 4'h1);
    wb(`DSOL_REG_CTRL, 0, 32'h0);
    wb(`DSOL_REG_PERM, 0, 32'h1f40);
    wt(1);
    test_done;
  end
endmodule
